// file: rtl/clock_gen_unit.sv
// clock mode select, fixed clock control and oscillator option logic
`timescale 1ns/10ps
`default_nettype none
module clock_gen_unit (
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire logic                        clk_en,
   input  wire logic                        ctrl_wr,
   input  wire clock_gen_pkg::clock_ctrl_t  ctrl_wdata,
   input  wire logic                        ext_ref_ok_status,
   input  wire logic                        osc_stable_status,
   input  wire logic                        loss_of_clock_status,
   input  wire logic                        lock_status,
   output clock_gen_pkg::clock_ctrl_t       ctrl_rdata,
   output clock_gen_pkg::clock_mode_t       actual_clock_mode,
   output clock_gen_pkg::analog_ctrl_t      analog_ctrl,
   output logic [7:0]                       ref_compare_div,
   output logic [7:0]                       out_divisor,
   output logic [4:0]                       loop_multiplier,
   output logic [7:0]                       loop_prescale,
   output logic                             fixed_clk_on,
   output logic                             fixed_clk_ext_half
);
   // ==========================================================
   // decode functions
   function automatic logic [4:0] mult_decode(input logic [2:0] code);
      mult_decode = {1'b0, code, 1'b0} + 5'h04;
   endfunction

   function automatic logic [7:0] div_decode(input logic [2:0] code);
      div_decode = 8'h01 << code;
   endfunction

   function automatic logic [7:0] pre_decode(input logic band);
      pre_decode = band ? clock_gen_pkg::PRESCALE_HIGH : clock_gen_pkg::PRESCALE_LOW;
   endfunction

   // ==========================================================
   // control register
   clock_gen_pkg::clock_ctrl_t  ctrl_q;
   logic                        first_wr_q;
   logic                        hg_wr_done_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_q       <= '0;
         first_wr_q   <= 1'b1;
         hg_wr_done_q <= 1'b0;
      end else if (clk_en && ctrl_wr) begin
         first_wr_q <= 1'b0;
         ctrl_q.requested_clock_mode  <= ctrl_wdata.requested_clock_mode;
         ctrl_q.range_high            <= ctrl_wdata.range_high;
         ctrl_q.loop_multiplier_field <= ctrl_wdata.loop_multiplier_field;
         ctrl_q.output_divider_field  <= ctrl_wdata.output_divider_field;
         if (first_wr_q) begin
            ctrl_q.reference_select <= ctrl_wdata.reference_select
                                       & ctrl_wdata.requested_clock_mode[1];
         end
         if (!hg_wr_done_q) begin
            hg_wr_done_q            <= 1'b1;
            ctrl_q.high_gain_select <= ctrl_wdata.high_gain_select;
         end
      end
   end

   assign ctrl_rdata = ctrl_q;

   // ==========================================================
   // target mode selection
   clock_gen_pkg::clock_mode_t target_mode;

   always_comb begin
      case (ctrl_q.requested_clock_mode)
         clock_gen_pkg::MODE_LK_INT:
            target_mode = osc_stable_status ? clock_gen_pkg::MODE_LK_INT
                                            : clock_gen_pkg::MODE_SELF;
         clock_gen_pkg::MODE_BYP:
            target_mode = ext_ref_ok_status ? clock_gen_pkg::MODE_BYP
                                            : clock_gen_pkg::MODE_SELF;
         clock_gen_pkg::MODE_LK_EXT:
            if (ext_ref_ok_status && osc_stable_status) begin
               target_mode = clock_gen_pkg::MODE_LK_EXT;
            end else if (loss_of_clock_status && ext_ref_ok_status) begin
               target_mode = clock_gen_pkg::MODE_BYP;
            end else begin
               target_mode = clock_gen_pkg::MODE_SELF;
            end
         default:
            target_mode = clock_gen_pkg::MODE_SELF;
      endcase
   end

   // ==========================================================
   // delayed status update
   clock_gen_pkg::clock_mode_t  mode_q;
   logic [clock_gen_pkg::CNT_W-1:0] dly_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dly_q <= '0;
      end else if (clk_en) begin
         if (ctrl_wr) begin
            dly_q <= clock_gen_pkg::CNT_W'(clock_gen_pkg::UPDATE_DELAY);
         end else if (dly_q != '0) begin
            dly_q <= dly_q - clock_gen_pkg::CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_q <= clock_gen_pkg::MODE_SELF;
      end else if (clk_en && !ctrl_wr && dly_q == '0) begin
         mode_q <= target_mode;
      end
   end

   assign actual_clock_mode = mode_q;

   // ==========================================================
   // locking divide tracking
   logic        ever_locked_q;
   logic [2:0]  mult_prev_q;
   logic        relock_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ever_locked_q <= 1'b0;
         mult_prev_q   <= '0;
         relock_q      <= 1'b0;
      end else if (clk_en) begin
         mult_prev_q <= ctrl_q.loop_multiplier_field;
         if (mode_q != clock_gen_pkg::MODE_LK_EXT) begin
            ever_locked_q <= 1'b0;
            relock_q      <= 1'b0;
         end else begin
            if (lock_status) begin
               ever_locked_q <= 1'b1;
               relock_q      <= 1'b0;
            end
            if (mult_prev_q != ctrl_q.loop_multiplier_field) begin
               relock_q <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // analog enables and dividers
   logic [15:0] ratio;
   logic        ext_half;

   always_comb begin
      ratio    = (16'(pre_decode(ctrl_q.range_high)) * 16'(mult_decode(ctrl_q.loop_multiplier_field)))
                 >> ctrl_q.output_divider_field;
      ext_half = (mode_q == clock_gen_pkg::MODE_LK_EXT) && lock_status
                 && (ratio >= clock_gen_pkg::FIXED_MIN_RAT);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         analog_ctrl        <= '0;
         ref_compare_div    <= clock_gen_pkg::REF_CMP_DIVIDE;
         out_divisor        <= div_decode(clock_gen_pkg::DIV_CODE_ONE);
         loop_multiplier    <= mult_decode('0);
         loop_prescale      <= clock_gen_pkg::PRESCALE_LOW;
         fixed_clk_on       <= 1'b0;
         fixed_clk_ext_half <= 1'b0;
      end else if (clk_en) begin
         analog_ctrl.ref_gen_on    <= (mode_q == clock_gen_pkg::MODE_LK_INT);
         analog_ctrl.osc_on        <= (mode_q != clock_gen_pkg::MODE_BYP);
         analog_ctrl.osc_open_loop <= (mode_q == clock_gen_pkg::MODE_SELF);
         analog_ctrl.amp_on        <= ctrl_q.reference_select;
         analog_ctrl.amp_high_gain <= ctrl_q.reference_select
                                      & ctrl_q.high_gain_select;
         analog_ctrl.div_by_two    <= (mode_q == clock_gen_pkg::MODE_LK_EXT)
                                      && (!ever_locked_q || relock_q);
         ref_compare_div <= (mode_q == clock_gen_pkg::MODE_LK_EXT)
                            ? clock_gen_pkg::REF_CMP_UNDIV
                            : clock_gen_pkg::REF_CMP_DIVIDE;
         out_divisor     <= div_decode(ctrl_q.output_divider_field);
         loop_multiplier <= mult_decode(ctrl_q.loop_multiplier_field);
         loop_prescale   <= pre_decode(ctrl_q.range_high);
         fixed_clk_on    <= (mode_q == clock_gen_pkg::MODE_BYP)
                            || (mode_q == clock_gen_pkg::MODE_LK_EXT);
         fixed_clk_ext_half <= ext_half;
      end
   end

   // ==========================================================
   // assertions
   AST_NO_SAME_CYCLE: assert property (@(posedge clk) disable iff (!rst_n)
      ctrl_wr |=> $stable(mode_q))
      else $error("actual mode changed right after write");
   AST_EXT_NEEDS_OK: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_q == clock_gen_pkg::MODE_LK_EXT && $past(mode_q) != clock_gen_pkg::MODE_LK_EXT)
      |-> $past(ext_ref_ok_status && osc_stable_status))
      else $error("locked external chosen without ok status");
   AST_STATUS_HELD: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_q != $past(mode_q))
      |-> $past(clk_en && !ctrl_wr && dly_q == '0))
      else $error("actual mode changed outside its update slot");
   AST_GAIN_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && ctrl_q.reference_select && ctrl_q.high_gain_select)
      |=> analog_ctrl.amp_high_gain)
      else $error("high gain not applied");
   AST_AMP_LOCKED_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && !ctrl_q.reference_select)
      |=> !analog_ctrl.amp_on)
      else $error("amplifier on without reference select");
   AST_LK_INT_RUN: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && mode_q == clock_gen_pkg::MODE_LK_INT)
      |=> analog_ctrl.ref_gen_on && analog_ctrl.osc_on)
      else $error("internal locked mode not running both sources");
   AST_BYP_STOP: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && mode_q == clock_gen_pkg::MODE_BYP)
      |=> !analog_ctrl.ref_gen_on && !analog_ctrl.osc_on)
      else $error("bypass mode left a source running");
   AST_SELF_OPEN: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && mode_q == clock_gen_pkg::MODE_SELF)
      |=> !analog_ctrl.ref_gen_on && analog_ctrl.osc_open_loop)
      else $error("self-clocked mode not open loop");
   AST_SELF_REF_DIV: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && mode_q == clock_gen_pkg::MODE_SELF)
      |=> ref_compare_div == clock_gen_pkg::REF_CMP_DIVIDE)
      else $error("self-clocked compare divider wrong");
   AST_DIV_TWO_LOCKING: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && mode_q == clock_gen_pkg::MODE_LK_EXT && !ever_locked_q)
      |=> analog_ctrl.div_by_two)
      else $error("no extra halving before first lock");
   AST_DIV_R_LOCKED: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && mode_q == clock_gen_pkg::MODE_LK_EXT && ever_locked_q && !relock_q)
      |=> !analog_ctrl.div_by_two)
      else $error("extra halving kept after lock");
   AST_FIXED_ON: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && (mode_q == clock_gen_pkg::MODE_BYP || mode_q == clock_gen_pkg::MODE_LK_EXT))
      |=> fixed_clk_on)
      else $error("fixed clock off in external modes");
   AST_HALF_RATIO: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && ratio < clock_gen_pkg::FIXED_MIN_RAT)
      |=> !fixed_clk_ext_half)
      else $error("fixed clock halved with low ratio");
   AST_PRESCALE_LOW: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && !ctrl_q.range_high)
      |=> loop_prescale == clock_gen_pkg::PRESCALE_LOW)
      else $error("low band prescale wrong");
   AST_FIXED_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && (mode_q == clock_gen_pkg::MODE_SELF || mode_q == clock_gen_pkg::MODE_LK_INT))
      |=> !fixed_clk_on)
      else $error("fixed clock on in internal mode");
   AST_HG_ONCE: assert property (@(posedge clk) disable iff (!rst_n)
      hg_wr_done_q |=> $stable(ctrl_q.high_gain_select))
      else $error("high gain changed after first write");
   AST_HG_GATED: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && !ctrl_q.reference_select) |=> !analog_ctrl.amp_high_gain)
      else $error("high gain active without reference select");
   AST_REF_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
      (!first_wr_q && !ctrl_q.reference_select) |=> !ctrl_q.reference_select)
      else $error("reference select set after first write");
   AST_FALLBACK: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && !ctrl_wr && dly_q == '0 && !ext_ref_ok_status && !osc_stable_status)
      |=> mode_q == clock_gen_pkg::MODE_SELF)
      else $error("no fallback to self-clocked");
   AST_HALF_DIV: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && mode_q != clock_gen_pkg::MODE_LK_EXT) |=> !fixed_clk_ext_half)
      else $error("fixed clock half rate outside locked external");
   AST_DELAY_UPDATE: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && ctrl_wr && !ext_ref_ok_status && !osc_stable_status)
      ##1 (clk_en && !ctrl_wr && !ext_ref_ok_status && !osc_stable_status) [*5]
      |=> mode_q == clock_gen_pkg::MODE_SELF)
      else $error("actual mode not updated");
   // ==========================================================
   // cover properties
   COV_EXT: cover property (@(posedge clk) mode_q == clock_gen_pkg::MODE_LK_EXT);
   COV_FALLBACK: cover property (@(posedge clk) mode_q != ctrl_q.requested_clock_mode);
   COV_RELOCK: cover property (@(posedge clk) relock_q);
   COV_BYP: cover property (@(posedge clk) mode_q == clock_gen_pkg::MODE_BYP);
   COV_HALF: cover property (@(posedge clk) fixed_clk_ext_half);
endmodule
`default_nettype wire

// file: rtl/clock_gen_pkg.sv
// constants and types of the clock mode select unit
package clock_gen_pkg;
   // ==========================================================
   // mode encodings
   typedef enum logic [1:0] {
      MODE_SELF   = 2'h0,
      MODE_LK_INT = 2'h1,
      MODE_BYP    = 2'h2,
      MODE_LK_EXT = 2'h3
   } clock_mode_t;

   // ==========================================================
   // control word fields
   typedef struct packed {
      logic        high_gain_select;
      logic        range_high;
      logic        reference_select;
      clock_mode_t requested_clock_mode;
      logic [2:0]  loop_multiplier_field;
      logic [2:0]  output_divider_field;
   } clock_ctrl_t;

   // analog enables and divide control out
   typedef struct packed {
      logic ref_gen_on;
      logic osc_on;
      logic osc_open_loop;
      logic amp_on;
      logic amp_high_gain;
      logic div_by_two;
   } analog_ctrl_t;

   // ==========================================================
   // constants
   localparam int unsigned UPDATE_DELAY   = 4;
   localparam int unsigned CNT_W          = 3;
   localparam logic [7:0]  REF_CMP_DIVIDE = 8'h07;
   localparam logic [7:0]  REF_CMP_UNDIV  = 8'h01;
   localparam logic [7:0]  PRESCALE_LOW   = 8'h40;
   localparam logic [7:0]  PRESCALE_HIGH  = 8'h01;
   localparam logic [15:0] FIXED_MIN_RAT  = 16'h0004;
   localparam logic [3:0]  FIXED_HALF_DIV = 4'h2;
   localparam logic [2:0]  DIV_CODE_ONE   = 3'h0;
endpackage

// file: test/ext_ref_model.sv
// external reference source model: reference good, oscillator stable, lock
`timescale 1ns/10ps
`default_nettype none
module ext_ref_model #(
   parameter int unsigned START_CYC = 3
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic present,
   input  wire logic stable_in,
   input  wire logic lock_in,
   output logic      ext_ref_ok_status,
   output logic      osc_stable_status,
   output logic      lock_status
);
   logic [7:0] start_q;
   // ==========================================================
   // start-up count, slow when START_CYC is large
   always_ff @(posedge clk) begin
      if (!rst_n || !present) begin
         start_q <= 8'h00;
      end else if (start_q < 8'(START_CYC)) begin
         start_q <= start_q + 8'h01;
      end
   end
   // ==========================================================
   // status levels; fixed clock is never taken as a source here
   always_ff @(posedge clk) begin
      ext_ref_ok_status <= rst_n && present && (start_q >= 8'(START_CYC));
      osc_stable_status <= rst_n && stable_in;
      lock_status       <= rst_n && present && lock_in;
   end
endmodule
`default_nettype wire

// file: test/test_clock_gen_unit.sv
// self-checking bench of the clock mode select unit
`timescale 1ns/10ps
`default_nettype none
module test_clock_gen_unit;
   logic clk, rst_n, clk_en, ctrl_wr, present, stable, lock_in, loss, ext_ok, osc_ok, lock_s;
   logic fixed_clk_on, fixed_clk_ext_half;
   logic [7:0] ref_compare_div, out_divisor, loop_prescale;
   logic [4:0] loop_multiplier;
   clock_gen_pkg::clock_ctrl_t  ctrl_wdata, ctrl_rdata;
   clock_gen_pkg::clock_mode_t  actual_clock_mode;
   clock_gen_pkg::analog_ctrl_t analog_ctrl;
   int error_cnt, n_checks;
   // ==========================================================
   // instances
   clock_gen_unit DUT (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .ctrl_wr(ctrl_wr),
      .ctrl_wdata(ctrl_wdata), .ext_ref_ok_status(ext_ok), .osc_stable_status(osc_ok),
      .loss_of_clock_status(loss), .lock_status(lock_s), .ctrl_rdata(ctrl_rdata),
      .actual_clock_mode(actual_clock_mode), .analog_ctrl(analog_ctrl),
      .ref_compare_div(ref_compare_div), .out_divisor(out_divisor),
      .loop_multiplier(loop_multiplier), .loop_prescale(loop_prescale),
      .fixed_clk_on(fixed_clk_on), .fixed_clk_ext_half(fixed_clk_ext_half));
   ext_ref_model #(.START_CYC(3)) src (.clk(clk), .rst_n(rst_n), .present(present),
      .stable_in(stable), .lock_in(lock_in), .ext_ref_ok_status(ext_ok),
      .osc_stable_status(osc_ok), .lock_status(lock_s));
   // ==========================================================
   // shared tasks
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
   endtask
   task automatic wr(input logic hg, input logic rh, input logic rs,
                     input clock_gen_pkg::clock_mode_t m, input logic [2:0] mf,
                     input logic [2:0] rf);
      @(negedge clk);
      ctrl_wr = 1'b1;
      ctrl_wdata = '{hg, rh, rs, m, mf, rf};
      @(negedge clk);
      ctrl_wr = 1'b0;
   endtask
   task automatic wait_mode(input clock_gen_pkg::clock_mode_t m);
      int i;
      for (i = 0; i < 40 && actual_clock_mode !== m; i++) @(negedge clk);
      if (i == 40) begin
         error_cnt++;
         $display("unexpected at %0t: mode wait ran out", $time);
         tally_and_finish();
      end
      repeat (3) @(negedge clk);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset();
      chk(16'(ctrl_rdata), 16'h0000, "ctrl reset");
      chk(16'(actual_clock_mode), 16'(clock_gen_pkg::MODE_SELF), "mode reset");
      chk(16'(ref_compare_div), 16'h0007, "ref div");
      chk(16'(out_divisor), 16'h0001, "divisor reset");
      chk(16'(loop_multiplier), 16'h0004, "mult reset");
      chk(16'(fixed_clk_on), 16'h0000, "fixed reset");
      $display("test reset done");
   endtask
   task automatic t_first_write();
      present = 1'b1;
      stable = 1'b1;
      wr(1'b1, 1'b0, 1'b1, clock_gen_pkg::MODE_LK_EXT, 3'h0, 3'h0);
      chk(16'(ctrl_rdata.reference_select), 16'h0001, "ref sel");
      chk(16'(actual_clock_mode), 16'(clock_gen_pkg::MODE_SELF), "early mode");
      wait_mode(clock_gen_pkg::MODE_LK_EXT);
      chk(16'(analog_ctrl.amp_high_gain), 16'h0001, "high gain");
      chk(16'(analog_ctrl.div_by_two), 16'h0001, "div two");
      chk(16'(fixed_clk_ext_half), 16'h0000, "half unlocked");
      chk(16'(loop_prescale), 16'h0040, "prescale low");
      lock_in = 1'b1;
      repeat (4) @(negedge clk);
      chk(16'(analog_ctrl.div_by_two), 16'h0000, "div two locked");
      chk(16'(fixed_clk_ext_half), 16'h0001, "half locked");
      $display("test first write done");
   endtask
   task automatic t_later_writes();
      for (int k = 0; k < 8; k++) begin
         wr(1'b0, 1'b1, 1'b0, clock_gen_pkg::MODE_LK_EXT, 3'(k), 3'(k));
         repeat (3) @(negedge clk);
         chk(16'(loop_multiplier), 16'(4 + 2 * k), "mult");
         chk(16'(out_divisor), 16'(1 << k), "divisor");
         chk(16'(ctrl_rdata.high_gain_select), 16'h0001, "gain kept");
      end
      chk(16'(loop_prescale), 16'h0001, "prescale high");
      wait_mode(clock_gen_pkg::MODE_LK_EXT);
      chk(16'(fixed_clk_ext_half), 16'h0000, "ratio low");
      chk(16'(fixed_clk_on), 16'h0001, "fixed on");
      $display("test later writes done");
   endtask
   task automatic t_modes();
      wr(1'b0, 1'b0, 1'b1, clock_gen_pkg::MODE_LK_INT, 3'h0, 3'h0);
      wait_mode(clock_gen_pkg::MODE_LK_INT);
      chk(16'(fixed_clk_on), 16'h0000, "fixed lk int");
      chk(16'({analog_ctrl.ref_gen_on, analog_ctrl.osc_on}), 16'h0003, "lk int");
      wr(1'b0, 1'b0, 1'b1, clock_gen_pkg::MODE_SELF, 3'h0, 3'h0);
      wait_mode(clock_gen_pkg::MODE_SELF);
      chk(16'(fixed_clk_on), 16'h0000, "fixed self");
      chk(16'({analog_ctrl.ref_gen_on, analog_ctrl.osc_open_loop}), 16'h0001, "self");
      chk(16'(ref_compare_div), 16'h0007, "self ref div");
      wr(1'b0, 1'b0, 1'b1, clock_gen_pkg::MODE_BYP, 3'h0, 3'h0);
      wait_mode(clock_gen_pkg::MODE_BYP);
      chk(16'({analog_ctrl.ref_gen_on, analog_ctrl.osc_on}), 16'h0000, "bypass");
      stable = 1'b0;
      wr(1'b0, 1'b0, 1'b1, clock_gen_pkg::MODE_LK_EXT, 3'h0, 3'h0);
      wait_mode(clock_gen_pkg::MODE_SELF);
      loss = 1'b1;
      wr(1'b0, 1'b0, 1'b1, clock_gen_pkg::MODE_LK_EXT, 3'h0, 3'h0);
      wait_mode(clock_gen_pkg::MODE_BYP);
      loss = 1'b0;
      present = 1'b0;
      wr(1'b0, 1'b0, 1'b1, clock_gen_pkg::MODE_BYP, 3'h0, 3'h0);
      wait_mode(clock_gen_pkg::MODE_SELF);
      chk(16'(ctrl_rdata.requested_clock_mode), 16'(clock_gen_pkg::MODE_BYP), "req");
      $display("test modes done");
   endtask
   task automatic t_ref_refused();
      do_reset();
      wr(1'b1, 1'b0, 1'b1, clock_gen_pkg::MODE_SELF, 3'h0, 3'h0);
      wr(1'b1, 1'b0, 1'b1, clock_gen_pkg::MODE_BYP, 3'h0, 3'h0);
      repeat (10) @(negedge clk);
      chk(16'(ctrl_rdata.reference_select), 16'h0000, "ref sel kept");
      chk(16'(analog_ctrl.amp_on), 16'h0000, "amp off");
      chk(16'(analog_ctrl.amp_high_gain), 16'h0000, "gain ignored");
      clk_en = 1'b0;
      wr(1'b0, 1'b0, 1'b0, clock_gen_pkg::MODE_LK_INT, 3'h2, 3'h0);
      chk(16'(ctrl_rdata.requested_clock_mode), 16'(clock_gen_pkg::MODE_BYP), "frozen");
      clk_en = 1'b1;
      $display("test reference refused done");
   endtask
   // ==========================================================
   // clock and main sequence
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      {rst_n, clk_en, ctrl_wr, present, stable, lock_in, loss} = 7'h20;
      ctrl_wdata = '0;
      error_cnt = 0;
      n_checks = 0;
      do_reset();
      t_reset();
      t_first_write();
      t_later_writes();
      t_modes();
      t_ref_refused();
      tally_and_finish();
   end
endmodule
`default_nettype wire
